//--- rtl/wdt_top.sv
// watchdog reset timer: period counter, stop/start, expiry actions
// assumes sys_clk stands for the RC oscillator clock and requests are
// level pulses from the CPU domain, synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top #(
  parameter int unsigned UNIT_CYC = `WDT_UNIT_CYC
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  // requests from software
  input  wire wdt_pkg::wdt_req_type  req,
  input  wire logic                  exc_en,
  input  wire logic                  flag_clr,
  // power and debug
  input  wire wdt_pkg::wdt_pwr_type  pwr,
  input  wire logic                  wake,
  input  wire logic                  flash_busy,
  // status and actions
  output logic [`WDT_CNT_W-1:0]      count,
  output logic                       running,
  output logic                       chip_rst_req,
  output logic                       exc_req,
  output logic                       prog_mode_req,
  output logic                       expiry_flag,
  output logic [`WDT_IDX_W-1:0]      idx_cur
);
  // the longest period must fit the counter
  if (UNIT_CYC < 1 ||
      UNIT_CYC > 32'hFFFF_FFFF / `WDT_MAX_UNITS) begin : g_unit_chk
    $error("UNIT_CYC cannot be served by the counter");
  end

  // synchronised requests
  logic rst_s, stop_s, wr_s;
  logic rst_d_r, stop_d_r, wr_d_r;
  wdt_sync u_s_rst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .d_in(req.restart), .d_out(rst_s));
  wdt_sync u_s_stop (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .d_in(req.stop), .d_out(stop_s));
  wdt_sync u_s_wr (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .d_in(req.idx_wr), .d_out(wr_s));
  wire logic rst_p  = rst_s & ~rst_d_r;
  wire logic stop_p = stop_s & ~stop_d_r;
  wire logic wr_p   = wr_s & ~wr_d_r;

  // index clamp
  wire logic [`WDT_IDX_W-1:0] idx_cl =
    (req.idx > `WDT_IDX_MAX) ? `WDT_IDX_MAX : req.idx;
  logic [`WDT_IDX_W-1:0] idx_r;
  logic [`WDT_CNT_W-1:0] period;
  wdt_period #(.UNIT_CYC(UNIT_CYC)) u_per (.idx(idx_r), .period(period));

  // state
  wdt_pkg::wdt_state_type st_r, st_nxt;
  logic [`WDT_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`WDT_IDX_W-1:0] idx_nxt;
  wire logic adv = ~pwr.sleep & ~pwr.dbg_stall;
  wire logic hit = (cnt_r + 32'h1 >= period);

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    case (st_r)
      wdt_pkg::WDT_ST_RUN: begin
        if (adv)
          cnt_nxt = cnt_r + 32'h1;
        if (adv && hit && !rst_p)
          st_nxt = wdt_pkg::WDT_ST_EXP;
        if (stop_p)
          st_nxt = wdt_pkg::WDT_ST_STOP;
        if (stop_p)
          cnt_nxt = cnt_r;
        if (rst_p)
          cnt_nxt = 32'h0;
        if (wr_p)
          idx_nxt = idx_cl;
      end
      wdt_pkg::WDT_ST_STOP: begin
        if (rst_p)
          cnt_nxt = 32'h0;
        if (wr_p) begin
          idx_nxt = idx_cl;
          st_nxt  = wdt_pkg::WDT_ST_RUN;
        end
      end
      wdt_pkg::WDT_ST_EXP: begin
        cnt_nxt = cnt_r;
      end
      default: begin
        st_nxt = wdt_pkg::WDT_ST_RUN;
      end
    endcase
    if (wake) begin
      st_nxt  = wdt_pkg::WDT_ST_RUN;
      cnt_nxt = 32'h0;
      idx_nxt = `WDT_IDX_MAX;
    end
  end

  wire logic expire = (st_r == wdt_pkg::WDT_ST_RUN) && adv && hit && !stop_p
                      && !rst_p && !wake;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= wdt_pkg::WDT_ST_RUN;
      cnt_r <= 32'h0;
      idx_r <= `WDT_IDX_MAX;
    end else if (clk_en) begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_d_r  <= 1'b0;
      stop_d_r <= 1'b0;
      wr_d_r   <= 1'b0;
    end else if (clk_en) begin
      rst_d_r  <= rst_s;
      stop_d_r <= stop_s;
      wr_d_r   <= wr_s;
    end
  end

  // expiry actions
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_rst_req  <= 1'b0;
      exc_req       <= 1'b0;
      prog_mode_req <= 1'b0;
    end else if (clk_en) begin
      chip_rst_req  <= expire & ~exc_en;
      exc_req       <= expire & exc_en;
      prog_mode_req <= expire & flash_busy;
    end
  end

  // expiry flag: not cleared by rst_b, set wins over clear
  logic flag_r = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (expire)
        flag_r <= 1'b1;
      else if (flag_clr)
        flag_r <= 1'b0;
    end
  end

  assign count       = cnt_r;
  assign running     = (st_r == wdt_pkg::WDT_ST_RUN);
  assign expiry_flag = flag_r;
  assign idx_cur     = idx_r;
endmodule : wdt_top
`default_nettype wire

//--- rtl/wdt_cfg.svh
// holds the constants of the watchdog reset timer
// assumes inclusion by bare name from the package and the design modules
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_IDX_W        4
`define WDT_IDX_MAX      4'hC
`define WDT_UNIT_MS      8
`define WDT_OSC_KHZ      32000
`define WDT_OSC_KHZ_ALT  27000
`define WDT_CLK_KHZ      10000
`define WDT_UNIT_CYC     (`WDT_UNIT_MS * `WDT_CLK_KHZ)
`define WDT_MAX_MS       16392
`define WDT_MAX_UNITS    2049
`define WDT_CNT_W        32
`define WDT_SYNC_STAGES  2
`endif

//--- rtl/wdt_pkg.sv
// holds the carrier types of the watchdog reset timer
// assumes the constants header sits beside it
`include "wdt_cfg.svh"
package wdt_pkg;
  typedef struct packed {
    logic                  restart;
    logic                  stop;
    logic                  idx_wr;
    logic [`WDT_IDX_W-1:0] idx;
  } wdt_req_type;
  typedef struct packed {
    logic doze;
    logic sleep;
    logic dbg_stall;
  } wdt_pwr_type;
  typedef enum logic [2:0] {
    WDT_ST_RUN  = 3'h1,
    WDT_ST_STOP = 3'h2,
    WDT_ST_EXP  = 3'h4
  } wdt_state_type;
endpackage : wdt_pkg

//--- rtl/wdt_sync.sv
// two-flop level synchroniser for one request bit
// assumes the destination clock is the watchdog clock
`timescale 1ns/1ps
`default_nettype none
module wdt_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // data
  input  wire logic d_in,
  output logic      d_out
);
  logic meta_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      d_out  <= 1'b0;
    end else if (clk_en) begin
      meta_r <= d_in;
      d_out  <= meta_r;
    end
  end
endmodule : wdt_sync
`default_nettype wire

//--- rtl/wdt_period.sv
// maps a timeout index to a count of watchdog clock cycles
// assumes the index has already been clamped
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_period #(
  parameter int unsigned UNIT_CYC = `WDT_UNIT_CYC
) (
  // index in
  input  wire logic [`WDT_IDX_W-1:0] idx,
  // period out
  output logic [`WDT_CNT_W-1:0]      period
);
  function automatic logic [`WDT_CNT_W-1:0] units(
    input logic [`WDT_IDX_W-1:0] p);
    logic [`WDT_CNT_W-1:0] u;
    u = 32'h1;
    if (p != 4'h0)
      u = (32'h1 << (p - 4'h1)) + 32'h1;
    return u;
  endfunction : units
  wire logic [63:0] prod = 64'(units(idx)) * 64'(UNIT_CYC);
  assign period = prod[`WDT_CNT_W-1:0];
endmodule : wdt_period
`default_nettype wire

//--- sim/wdt_properties.sv
// concurrent checks on the watchdog reset timer ports
// assumes binding onto wdt_top with its UNIT_CYC
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_props #(
  parameter int unsigned UNIT_CYC = `WDT_UNIT_CYC
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  // inputs
  input wire wdt_pkg::wdt_req_type  req,
  input wire logic                  exc_en,
  input wire logic                  flag_clr,
  input wire wdt_pkg::wdt_pwr_type  pwr,
  input wire logic                  wake,
  input wire logic                  flash_busy,
  // outputs
  input wire logic [`WDT_CNT_W-1:0] count,
  input wire logic                  running,
  input wire logic                  chip_rst_req,
  input wire logic                  exc_req,
  input wire logic                  prog_mode_req,
  input wire logic                  expiry_flag,
  input wire logic [`WDT_IDX_W-1:0] idx_cur
);
  function automatic logic [31:0] per(input logic [3:0] p);
    per = (p == 4'h0) ? UNIT_CYC
                      : ((32'h1 << (p - 4'h1)) + 32'h1) * UNIT_CYC;
  endfunction : per
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_stop_freeze: assert property (!running && !$past(running) |->
    $stable(count)) else $error("count moved while halted");
  a_pause_hold: assert property (pwr.sleep || pwr.dbg_stall |=>
    count == $past(count) || count == 0) else $error("count ran paused");
  a_wake_init: assert property (wake |=>
    running && count == 0 && idx_cur == 4'hC) else $error("wake state");
  a_rst_pulse: assert property (chip_rst_req |->
    !$past(exc_en) && !running ##1 !chip_rst_req) else $error("reset pulse");
  a_exc_pulse: assert property (exc_req |->
    $past(exc_en) && expiry_flag) else $error("exception pulse");
  a_prog_pulse: assert property (prog_mode_req |->
    $past(flash_busy) && expiry_flag) else $error("programming pulse");
  a_period_bound: assert property (running && $stable(idx_cur) |->
    count < per(idx_cur)) else $error("count beyond period");
  a_restart_zero: assert property ($rose(req.restart) && running |->
    ##[2:4] count == 0) else $error("restart missed");
  a_flag_kept: assert property (disable iff (1'b0)
    expiry_flag && !flag_clr |=> expiry_flag) else $error("flag lost");
endmodule : wdt_props
bind wdt_top wdt_props #(.UNIT_CYC(UNIT_CYC)) props_u (.*);
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the watchdog reset timer
// assumes design, package and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module testbench;
  localparam int unsigned UC = 4;
  localparam int RS = 6;
  localparam int ST = 5;
  localparam int IW = 4;
  logic                  sys_clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  clk_en = 1'b1;
  wdt_pkg::wdt_req_type  req = '0;
  logic                  exc_en = 1'b0;
  logic                  flag_clr = 1'b0;
  wdt_pkg::wdt_pwr_type  pwr = '0;
  logic                  wake = 1'b0;
  logic                  flash_busy = 1'b0;
  logic [`WDT_CNT_W-1:0] count, c, per;
  logic                  running, chip_rst_req, exc_req;
  logic                  prog_mode_req, expiry_flag;
  logic [`WDT_IDX_W-1:0] idx_cur;
  int                    fails = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  int                    n;
  wdt_top #(.UNIT_CYC(UC)) dut_u (.*);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task pulse_req(input int b);
    req[b] = 1'b1;
    cyc(4);
    req[b] = 1'b0;
    cyc(4);
  endtask : pulse_req
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(2);
    rst_b = 1'b1;
    chk(running === 1'b1 && idx_cur === 4'hC, "reset state");
    chk(expiry_flag === 1'b0, "flag at power-up");
    pwr.doze = 1'b1;
    cyc(20);
    c = count;
    cyc(5);
    chk(count === c + 5, "count read");
    req.restart = 1'b1;
    cyc(4);
    chk(count < 4 && idx_cur === 4'hC, "restart");
    req.restart = 1'b0;
    cyc(4);
    pwr.sleep = 1'b1;
    c = count;
    cyc(5);
    chk(count === c, "sleep hold");
    pwr.sleep = 1'b0;
    $display("test basic done");
    for (int p = 0; p <= 12; p++) begin
      wake = 1'b1;
      pwr.dbg_stall = 1'b1;
      cyc(1);
      wake = 1'b0;
      pulse_req(ST);
      chk(running === 1'b0 && count === 0, "stall stop");
      pwr.dbg_stall = 1'b0;
      cyc(3);
      chk(running === 1'b0 && count === 0, "stopped");
      exc_en = p[0];
      flash_busy = (p == 3);
      req.idx = p[3:0];
      req.idx_wr = 1'b1;
      n = 0;
      while (running !== 1'b1 && n < 10) begin
        cyc(1);
        n++;
      end
      per = (p == 0) ? UC : ((32'h1 << (p - 1)) + 1) * UC;
      n = 0;
      while (running === 1'b1 && n < 9000) begin
        cyc(1);
        n++;
      end
      chk(n == per && idx_cur === p[3:0], "period");
      chk(expiry_flag === 1'b1, "flag set");
      chk(exc_req === p[0] && chip_rst_req === !p[0], "act");
      chk(prog_mode_req === (p == 3), "flash");
      req.idx_wr = 1'b0;
      cyc(3);
    end
    $display("test periods done");
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    pulse_req(RS);
    req.idx = 4'h4;
    pulse_req(IW);
    chk(idx_cur === 4'h4 && running === 1'b1, "retune");
    pulse_req(ST);
    c = count;
    cyc(3);
    chk(running === 1'b0 && count === c, "stop hold");
    rst_b = 1'b0;
    cyc(1);
    rst_b = 1'b1;
    chk(running === 1'b1 && idx_cur === 4'hC, "reset run");
    chk(count === 0 && expiry_flag === 1'b1, "flag kept");
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    chk(expiry_flag === 1'b0, "flag clear");
    pulse_req(IW);
    chk(idx_cur === 4'h4 && running === 1'b1, "rewrite");
    req.idx = 4'hF;
    pulse_req(IW);
    chk(idx_cur === 4'hC && running === 1'b1, "clamp");
    $display("test flag done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
